/* File: core/usb_ctl_params.svh */
// Offsets, field positions, reset values and timing counts of the USB control block
`ifndef USB_CTL_PARAMS_SVH
`define USB_CTL_PARAMS_SVH
// Byte addresses on the register bus
`define ADDR_FUNC_CTL 8'h00
`define ADDR_SEL_STAT 8'h04
`define ADDR_MISC_CTL 8'h08
`define ADDR_MCU_CFG 8'h0c
// Field positions in usb_function_control
`define BIT_TRANSFER_DIR 0
`define BIT_SETUP_IN_PROGRESS 1
`define BIT_SELF_POWERED 2
`define BIT_REMOTE_WAKEUP_EN 3
`define BIT_LINK_ENABLE 4
`define BIT_WAKEUP_REQUEST 5
`define BIT_PULLUP_CONNECT 7
// Plain read/write bits of usb_function_control (request and reserved excluded)
`define FUNC_CTL_RW_MASK 8'h9f
// Reset values
`define FUNC_CTL_RST 8'h00
`define LINK_RST_DEFAULT 1'b1
`define MISC_CTL_RST 8'h00
`define MCU_CFG_RST 8'h00
// Wake-up pulse length in core clock cycles
`define WAKEUP_PULSE_CYCLES 16
// Number of product-select pins
`define SELECT_PIN_COUNT 4
`endif

/* File: core/usb_ctl_pkg.sv */
// Types shared by the USB control block
package usb_ctl_pkg;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  // Classic Wishbone answer from the slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
  // Wake-up pulse phases
  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_phase_t;
  typedef struct packed {
    pulse_phase_t phase;
    logic [7:0] count;
    logic pulse;
  } pulse_state_t;
  // Two-stage pin synchroniser
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } sync_state_t;
  // Top-level state
  typedef struct packed {
    logic [7:0] func_ctl;
    logic [7:0] misc_ctl;
    logic [7:0] mcu_cfg;
    logic ack;
    logic [31:0] rdat;
    logic int_rst;
  } top_state_t;
endpackage : usb_ctl_pkg

/* File: core/select_pin_sync.sv */
// Two-flop synchroniser for the product-select pins
`timescale 1ns/10ps
`include "usb_ctl_params.svh"
module select_pin_sync (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Internal reset, active high
  input wire logic [`SELECT_PIN_COUNT-1:0] pin_i, // Raw pins
  output logic [`SELECT_PIN_COUNT-1:0] sync_o // Synchronised pins
);
  usb_ctl_pkg::sync_state_t state_reg;
  usb_ctl_pkg::sync_state_t state_next;
  logic [`SELECT_PIN_COUNT-1:0] meta_next;
  logic [`SELECT_PIN_COUNT-1:0] sync_next;

  // Per-pin stages; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < `SELECT_PIN_COUNT; i++)
    begin : g_pin
      assign meta_next[i] = rst_i ? 1'b0 : pin_i[i];
      assign sync_next[i] = rst_i ? 1'b0 : state_reg.meta[i];
    end
  endgenerate

  // Pack next state
  always_comb
  begin
    state_next = state_reg;
    state_next.meta = meta_next;
    state_next.sync = sync_next;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  assign sync_o = state_reg.sync;

  property p_sync_delay;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |-> sync_o == $past(pin_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // RULE13
    else $error("Select pins not seen two cycles later");
endmodule : select_pin_sync

/* File: core/wakeup_pulse.sv */
// Remote wake-up pulse generator
`timescale 1ns/10ps
`include "usb_ctl_params.svh"
module wakeup_pulse #(
  parameter int unsigned PULSE_CYCLES = `WAKEUP_PULSE_CYCLES
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Internal reset, active high
  input wire logic request_i, // Pending wake-up request
  output logic pulse_o, // Wake-up pulse, registered
  output logic done_o // Last cycle of the pulse
);
  usb_ctl_pkg::pulse_state_t state_reg;
  usb_ctl_pkg::pulse_state_t state_next;
  logic [8:0] width_reg;

  // Start on request, hold for the programmed length
  always_comb
  begin
    state_next = state_reg;
    case (state_reg.phase)
      usb_ctl_pkg::PULSE_IDLE:
        if (request_i)
        begin
          state_next.phase = usb_ctl_pkg::PULSE_ACTIVE; // RULE5
          state_next.count = 8'(PULSE_CYCLES - 1); // RULE15
          state_next.pulse = 1'b1;
        end
      usb_ctl_pkg::PULSE_ACTIVE:
        if (state_reg.count == 8'h00)
        begin
          state_next.phase = usb_ctl_pkg::PULSE_IDLE;
          state_next.pulse = 1'b0;
        end
        else
        begin
          state_next.count = state_reg.count - 8'h01;
        end
      default:
        state_next.phase = usb_ctl_pkg::PULSE_IDLE;
    endcase
    if (rst_i)
    begin
      state_next = '{usb_ctl_pkg::PULSE_IDLE, 8'h00, 1'b0};
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  assign pulse_o = state_reg.pulse;
  assign done_o = (state_reg.phase == usb_ctl_pkg::PULSE_ACTIVE) && (state_reg.count == 8'h00);

  // Pulse width counter for checking
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pulse_o)
      width_reg <= 9'h000;
    else
      width_reg <= width_reg + 9'h001;
  end

  property p_pulse_width;
    @(posedge clk_i) disable iff (rst_i)
    $fell(pulse_o) && !$past(rst_i) |-> width_reg == 9'(PULSE_CYCLES);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // RULE15
    else $error("Wake-up pulse has wrong length");
endmodule : wakeup_pulse

/* File: core/usb_function_control_top.sv */
// USB function control register bank with reset linking and select-pin status
//
// Notes on behaviour
// [RULE1] Firmware sets setup_in_progress while it serves the setup-packet interrupt.
// [RULE2] Firmware clears setup_in_progress before it leaves that interrupt routine.
// [RULE3] Bit 2 is the power source, 0 bus-powered and 1 self-powered, read and write.
// [RULE4] Firmware sets or clears remote_wakeup_enable (bit 3) as the host enables it.
// [RULE5] Writing 1 to wakeup_request (bit 5) sends one remote wake-up pulse upstream.
// [RULE6] wakeup_request clears itself after the pulse, and writing 0 to it does nothing.
// [RULE7] pullup_connect (bit 7) drives the pullup output high when 1 and low when 0.
// [RULE8] The USB function reset reaches the internal reset only while bit 4 is set.
// [RULE9] The internal reset is active with the power-up reset or the linked function reset.
// [RULE10] The internal reset clears all logic except the control, misc and configuration registers.
// [RULE11] Control and configuration registers are cleared by the power-up reset only.
// [RULE12] product_select_status shows the four select pins in bits 3..0, zeros above.
// [RULE13] Select bits 0 and 1 come from the shared port 3 pins, bits 2 and 3 dedicated.
// [RULE14] The power-up value of the reset link bit is a parameter, defaulting to 1.
// [RULE15] The wake-up pulse length is a parameter in clock cycles; the request ends with it.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "usb_ctl_params.svh"
module usb_function_control_top #(
  parameter logic LINK_RESET_VALUE = `LINK_RST_DEFAULT, // Power-up reset link value
  parameter int unsigned WAKEUP_PULSE_CYCLES = `WAKEUP_PULSE_CYCLES // Pulse length
) (
  input wire logic clk_i, // Core clock, 100 MHz
  input wire logic rst_i, // Power-up reset, synchronous, active high
  input wire usb_ctl_pkg::wb_req_t wb_req_i, // Wishbone request
  output usb_ctl_pkg::wb_rsp_t wb_rsp_o, // Wishbone answer
  input wire logic usb_function_reset_i, // USB function reset from the engine
  input wire logic port3_bit0_i, // Shared pin, select bit 0
  input wire logic port3_bit1_i, // Shared pin, select bit 1
  input wire logic select2_i, // Dedicated select pin 2
  input wire logic select3_i, // Dedicated select pin 3
  output logic internal_reset_o, // Internal reset to the rest of the chip
  output logic pullup_output_o, // Pullup drive toward upstream port
  output logic wakeup_pulse_o, // Remote wake-up signalling pulse
  output logic transfer_dir_o, // Data direction of the control transfer
  output logic setup_in_progress_o, // Setup handling under way
  output logic self_powered_o, // Power source indication
  output logic remote_wakeup_enable_o // Remote wake-up feature enabled
);
  usb_ctl_pkg::top_state_t state_reg;
  usb_ctl_pkg::top_state_t state_next;
  logic int_rst;
  logic take;
  logic wr_low;
  logic ctl_wr;
  logic pulse_done;
  logic [3:0] select_sync;
  logic [7:0] func_ctl_rst;

  // Internal reset: power-up reset or linked function reset
  assign int_rst = rst_i
    || (usb_function_reset_i && state_reg.func_ctl[`BIT_LINK_ENABLE]); // RULE8 RULE9

  // Bus request taken once per cycle pair; blocked while internal reset is active
  assign take = wb_req_i.cyc && wb_req_i.stb && !state_reg.ack && !int_rst;
  assign wr_low = take && wb_req_i.we && wb_req_i.sel[0];
  assign ctl_wr = wr_low && (wb_req_i.adr == `ADDR_FUNC_CTL);

  // Power-up value of the control register with the link bit from the parameter
  always_comb
  begin
    func_ctl_rst = `FUNC_CTL_RST;
    func_ctl_rst[`BIT_LINK_ENABLE] = LINK_RESET_VALUE; // RULE14
  end

  // Select pins: shared port 3 pins low, dedicated pins high
  select_pin_sync u_select_sync (
    .clk_i(clk_i),
    .rst_i(int_rst),
    .pin_i({select3_i, select2_i, port3_bit1_i, port3_bit0_i}), // RULE13
    .sync_o(select_sync)
  );

  // Wake-up pulse generator, driven by the pending request bit
  wakeup_pulse #(
    .PULSE_CYCLES(WAKEUP_PULSE_CYCLES)
  ) u_wakeup (
    .clk_i(clk_i),
    .rst_i(int_rst),
    .request_i(state_reg.func_ctl[`BIT_WAKEUP_REQUEST]), // RULE5
    .pulse_o(wakeup_pulse_o),
    .done_o(pulse_done)
  );

  // Next state of registers and bus answer
  always_comb
  begin
    state_next = state_reg;
    // Request self-clears at the end of the pulse
    if (pulse_done)
    begin
      state_next.func_ctl[`BIT_WAKEUP_REQUEST] = 1'b0; // RULE6
    end
    // Register writes; writing 0 to the request leaves it alone and a new set wins
    if (ctl_wr)
    begin
      state_next.func_ctl = (state_next.func_ctl & ~`FUNC_CTL_RW_MASK)
        | (wb_req_i.dat[7:0] & `FUNC_CTL_RW_MASK); // RULE3 RULE7
      if (wb_req_i.dat[`BIT_WAKEUP_REQUEST])
      begin
        state_next.func_ctl[`BIT_WAKEUP_REQUEST] = 1'b1; // RULE5 RULE6
      end
    end
    if (wr_low && (wb_req_i.adr == `ADDR_MISC_CTL))
    begin
      state_next.misc_ctl = wb_req_i.dat[7:0];
    end
    if (wr_low && (wb_req_i.adr == `ADDR_MCU_CFG))
    begin
      state_next.mcu_cfg = wb_req_i.dat[7:0];
    end
    // Bus answer: one-cycle ack, read data valid with it, unmapped reads zero
    state_next.ack = take;
    state_next.rdat = 32'h0000_0000;
    if (take && !wb_req_i.we)
    begin
      case (wb_req_i.adr)
        `ADDR_FUNC_CTL: state_next.rdat = {24'h00_0000, state_reg.func_ctl};
        `ADDR_SEL_STAT: state_next.rdat = {28'h000_0000, select_sync}; // RULE12
        `ADDR_MISC_CTL: state_next.rdat = {24'h00_0000, state_reg.misc_ctl};
        `ADDR_MCU_CFG: state_next.rdat = {24'h00_0000, state_reg.mcu_cfg};
        default: state_next.rdat = 32'h0000_0000;
      endcase
    end
    state_next.int_rst = int_rst; // RULE9
    // Internal reset clears the bus logic but not the control registers
    if (int_rst)
    begin
      state_next.ack = 1'b0; // RULE10
      state_next.rdat = 32'h0000_0000;
    end
    // Only the power-up reset clears the control and configuration registers
    if (rst_i)
    begin
      state_next.func_ctl = func_ctl_rst; // RULE11
      state_next.misc_ctl = `MISC_CTL_RST;
      state_next.mcu_cfg = `MCU_CFG_RST;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  // Outputs straight from the state register
  assign wb_rsp_o.ack = state_reg.ack;
  assign wb_rsp_o.dat = state_reg.rdat;
  assign internal_reset_o = state_reg.int_rst;
  assign pullup_output_o = state_reg.func_ctl[`BIT_PULLUP_CONNECT]; // RULE7
  assign transfer_dir_o = state_reg.func_ctl[`BIT_TRANSFER_DIR];
  assign setup_in_progress_o = state_reg.func_ctl[`BIT_SETUP_IN_PROGRESS];
  assign self_powered_o = state_reg.func_ctl[`BIT_SELF_POWERED]; // RULE3
  assign remote_wakeup_enable_o = state_reg.func_ctl[`BIT_REMOTE_WAKEUP_EN];

  property p_pullup_follows_write;
    @(posedge clk_i) disable iff (rst_i)
    ctl_wr |=> pullup_output_o == $past(wb_req_i.dat[7]);
  endproperty
  a_pullup_follows_write: assert property (p_pullup_follows_write) // RULE7
    else $error("Pullup output does not follow written bit");

  property p_power_source;
    @(posedge clk_i) disable iff (rst_i)
    ctl_wr |=> self_powered_o == $past(wb_req_i.dat[2]) ##1 !wb_rsp_o.ack;
  endproperty
  a_power_source: assert property (p_power_source) // RULE3
    else $error("Power source bit not stored or ack not single");

  property p_wakeup_starts;
    @(posedge clk_i) disable iff (int_rst)
    ctl_wr && wb_req_i.dat[5] && !state_reg.func_ctl[5] && !wakeup_pulse_o
      |-> ##2 wakeup_pulse_o;
  endproperty
  a_wakeup_starts: assert property (p_wakeup_starts) // RULE5
    else $error("Wake-up request gave no pulse");

  property p_zero_write_no_effect;
    @(posedge clk_i) disable iff (rst_i)
    ctl_wr && !wb_req_i.dat[5] && !state_reg.func_ctl[5] |=> !state_reg.func_ctl[5];
  endproperty
  a_zero_write_no_effect: assert property (p_zero_write_no_effect) // RULE6
    else $error("Writing 0 set the wake-up request");

  property p_request_self_clears;
    @(posedge clk_i) disable iff (rst_i)
    pulse_done && !(ctl_wr && wb_req_i.dat[5]) |=> !state_reg.func_ctl[5] && !wakeup_pulse_o;
  endproperty
  a_request_self_clears: assert property (p_request_self_clears) // RULE6
    else $error("Wake-up request not cleared after pulse");

  property p_reset_blocked;
    @(posedge clk_i)
    !rst_i && !state_reg.func_ctl[4] |=> !internal_reset_o;
  endproperty
  a_reset_blocked: assert property (p_reset_blocked) // RULE8
    else $error("Function reset passed while link bit clear");

  property p_reset_combined;
    @(posedge clk_i)
    rst_i || (usb_function_reset_i && state_reg.func_ctl[4]) |=> internal_reset_o;
  endproperty
  a_reset_combined: assert property (p_reset_combined) // RULE9
    else $error("Internal reset missing");

  property p_int_reset_clears_bus;
    @(posedge clk_i)
    int_rst |=> !wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000;
  endproperty
  a_int_reset_clears_bus: assert property (p_int_reset_clears_bus) // RULE10
    else $error("Bus logic not cleared by internal reset");

  property p_ctl_survives_function_reset;
    @(posedge clk_i)
    !rst_i && int_rst |=> (state_reg.func_ctl & 8'hdf) == ($past(state_reg.func_ctl) & 8'hdf)
      && state_reg.mcu_cfg == $past(state_reg.mcu_cfg);
  endproperty
  a_ctl_survives_function_reset: assert property (p_ctl_survives_function_reset) // RULE11
    else $error("Function reset changed control register");

  property p_select_readback;
    @(posedge clk_i) disable iff (int_rst)
    take && !wb_req_i.we && wb_req_i.adr == `ADDR_SEL_STAT
      |=> wb_rsp_o.ack && wb_rsp_o.dat == {28'h000_0000, $past(select_sync)};
  endproperty
  a_select_readback: assert property (p_select_readback) // RULE12
    else $error("Select status read wrong");

  property p_link_power_up;
    @(posedge clk_i)
    rst_i |=> state_reg.func_ctl[4] == LINK_RESET_VALUE && !pullup_output_o;
  endproperty
  a_link_power_up: assert property (p_link_power_up) // RULE14
    else $error("Link bit wrong after power-up reset");

  property p_power_source_held;
    @(posedge clk_i) disable iff (rst_i)
    !ctl_wr |=> $stable(self_powered_o);
  endproperty
  a_power_source_held: assert property (p_power_source_held) // RULE3
    else $error("Power source bit changed without a write");

  property p_pullup_held;
    @(posedge clk_i) disable iff (rst_i)
    !ctl_wr |=> $stable(pullup_output_o);
  endproperty
  a_pullup_held: assert property (p_pullup_held) // RULE7
    else $error("Pullup output changed without a write");

  property p_link_held;
    @(posedge clk_i) disable iff (rst_i)
    !ctl_wr |=> $stable(state_reg.func_ctl[4]);
  endproperty
  a_link_held: assert property (p_link_held) // RULE11
    else $error("Link bit changed without a write or power-up reset");

  property p_pulse_needs_request;
    @(posedge clk_i) disable iff (rst_i)
    $rose(wakeup_pulse_o) |-> state_reg.func_ctl[5];
  endproperty
  a_pulse_needs_request: assert property (p_pulse_needs_request) // RULE5
    else $error("Wake-up pulse started with no request");

  property p_request_held;
    @(posedge clk_i) disable iff (rst_i)
    state_reg.func_ctl[5] && !pulse_done |=> state_reg.func_ctl[5];
  endproperty
  a_request_held: assert property (p_request_held) // RULE6
    else $error("Wake-up request dropped before the pulse ended");

  property p_internal_reset_cause;
    @(posedge clk_i)
    internal_reset_o |-> $past(rst_i)
      || ($past(usb_function_reset_i) && $past(state_reg.func_ctl[4]));
  endproperty
  a_internal_reset_cause: assert property (p_internal_reset_cause) // RULE9
    else $error("Internal reset without a cause");

  property p_misc_survives_function_reset;
    @(posedge clk_i)
    !rst_i && int_rst |=> state_reg.misc_ctl == $past(state_reg.misc_ctl);
  endproperty
  a_misc_survives_function_reset: assert property (p_misc_survives_function_reset) // RULE10
    else $error("Function reset changed misc register");

  property p_select_cleared;
    @(posedge clk_i)
    int_rst |=> select_sync == 4'h0;
  endproperty
  a_select_cleared: assert property (p_select_cleared) // RULE10
    else $error("Select synchroniser not cleared by internal reset");

  property p_pulse_cleared;
    @(posedge clk_i)
    int_rst |=> !wakeup_pulse_o;
  endproperty
  a_pulse_cleared: assert property (p_pulse_cleared) // RULE10
    else $error("Wake-up pulse not cleared by internal reset");

  property p_scratch_power_up;
    @(posedge clk_i)
    rst_i |=> state_reg.misc_ctl == `MISC_CTL_RST && state_reg.mcu_cfg == `MCU_CFG_RST;
  endproperty
  a_scratch_power_up: assert property (p_scratch_power_up) // RULE11
    else $error("Misc or config register not cleared by power-up reset");
endmodule : usb_function_control_top

/* File: test/usb_upstream_model.sv */
// Upstream port model: sees the connect level and measures wake-up pulses
`timescale 1ns/10ps
module usb_upstream_model (
  input wire logic clk_i, // Core clock
  input wire logic pullup_i, // Pullup drive from the device
  input wire logic wakeup_i, // Wake-up signalling from the device
  output logic connected_o, // Host sees a connection
  output int pulses_o, // Wake-up pulses seen
  output int width_o // Width of the last pulse in cycles
);
  int run;
  // A driven-high pullup is a connection, low is a disconnect
  assign connected_o = pullup_i;
  // Count pulses and their widths at each rising clock edge
  initial
  begin
    pulses_o = 0;
    width_o = 0;
    run = 0;
    forever
    begin
      @(posedge clk_i);
      if (wakeup_i === 1'b1)
        run = run + 1;
      else if (run != 0)
      begin
        pulses_o = pulses_o + 1;
        width_o = run;
        run = 0;
      end
    end
  end
endmodule : usb_upstream_model

/* File: test/tb_usb_function_control_top.sv */
// Testbench for the USB function control register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_usb_function_control_top;
  localparam int PW = 4;
  logic clk_i;
  logic rst_i;
  usb_ctl_pkg::wb_req_t req;
  usb_ctl_pkg::wb_rsp_t rsp;
  logic frst;
  logic [3:0] pins;
  logic irst, pull, wake, dir, sip, spw, remote_wakeup_enable, conn;
  int pulses, width, p0, n;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'hc8f913a4;
  logic [7:0] ctl_m, misc_m, cfg_m, q;
  usb_function_control_top #(.LINK_RESET_VALUE(1'b1), .WAKEUP_PULSE_CYCLES(PW)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .usb_function_reset_i(frst), .port3_bit0_i(pins[0]), .port3_bit1_i(pins[1]),
    .select2_i(pins[2]), .select3_i(pins[3]), .internal_reset_o(irst),
    .pullup_output_o(pull), .wakeup_pulse_o(wake), .transfer_dir_o(dir),
    .setup_in_progress_o(sip), .self_powered_o(spw), .remote_wakeup_enable_o(remote_wakeup_enable));
  usb_upstream_model host (.clk_i(clk_i), .pullup_i(pull), .wakeup_i(wake),
    .connected_o(conn), .pulses_o(pulses), .width_o(width));
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= we;
    req.adr <= a;
    req.sel <= 4'hf;
    req.dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (rsp.ack !== 1'b1 && k < 50);
    `CHK("ack", 1'b1, rsp.ack)
    q = rsp.dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Read the control register and compare it and its outputs
  task automatic chk_ctl();
    wb(1'b0, 8'h00, 8'h00);
    `CHK("ctl", ctl_m, q)
    `CHK("ctl_out", ctl_m & 8'h8f, {conn, 3'b0, remote_wakeup_enable, spw, sip, dir})
  endtask : chk_ctl
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    frst = 1'b0;
    pins = 4'h0;
    ctl_m = 8'h10;
    misc_m = 8'h00;
    cfg_m = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_ctl();
    wb(1'b0, 8'h0c, 8'h00);
    `CHK("cfg", cfg_m, q)
    $display("test reset_values done");
    ctl_m = 8'h12;
    wb(1'b1, 8'h00, ctl_m);
    chk_ctl();
    ctl_m = 8'h10;
    wb(1'b1, 8'h00, ctl_m);
    chk_ctl();
    repeat (6)
    begin
      seed = lfsr(seed);
      ctl_m = seed[7:0] & 8'h9f;
      wb(1'b1, 8'h00, seed[7:0] & 8'hdf);
      chk_ctl();
    end
    misc_m = 8'h5a;
    wb(1'b1, 8'h08, misc_m);
    cfg_m = 8'ha5;
    wb(1'b1, 8'h0c, cfg_m);
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    `CHK("unmapped", 8'h00, q)
    wb(1'b0, 8'h08, 8'h00);
    `CHK("misc", misc_m, q)
    $display("test register_access done");
    repeat (4)
    begin
      seed = lfsr(seed);
      pins <= seed[3:0];
      repeat (3) @(posedge clk_i);
      wb(1'b0, 8'h04, 8'h00);
      `CHK("select", {4'h0, pins}, q)
    end
    $display("test select_pins done");
    p0 = pulses;
    wb(1'b1, 8'h00, ctl_m | 8'h20);
    wb(1'b1, 8'h00, ctl_m);
    n = 0;
    while (pulses == p0 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("pulses", p0 + 1, pulses)
    `CHK("width", PW, width)
    chk_ctl();
    wb(1'b1, 8'h00, ctl_m);
    repeat (PW + 4) @(posedge clk_i);
    `CHK("no_pulse", p0 + 1, pulses)
    $display("test wakeup done");
    ctl_m = 8'h90;
    wb(1'b1, 8'h00, ctl_m);
    frst <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("irst_linked", 1'b1, irst)
    frst <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("irst_off", 1'b0, irst)
    chk_ctl();
    wb(1'b0, 8'h08, 8'h00);
    `CHK("misc_kept", misc_m, q)
    wb(1'b0, 8'h0c, 8'h00);
    `CHK("cfg_kept", cfg_m, q)
    ctl_m = 8'h80;
    wb(1'b1, 8'h00, ctl_m);
    frst <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("irst_blocked", 1'b0, irst)
    chk_ctl();
    frst <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("irst_power", 1'b1, irst)
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ctl_m = 8'h10;
    misc_m = 8'h00;
    chk_ctl();
    wb(1'b0, 8'h08, 8'h00);
    `CHK("misc_clr", misc_m, q)
    cfg_m = 8'h00;
    wb(1'b0, 8'h0c, 8'h00);
    `CHK("cfg_clr", cfg_m, q)
    $display("test reset_link done");
    close_out();
  end
endmodule : tb_usb_function_control_top
